// ### inc/timer01_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * two-timer and external-interrupt control block.
 * Assumes inclusion by bare name from design files.
 */
`ifndef TIMER01_MAP_SVH
`define TIMER01_MAP_SVH

`define T01_ADDR_TCTRL      8'h88
`define T01_ADDR_TMODE      8'h89
`define T01_ADDR_T0LO       8'h8A
`define T01_ADDR_T1LO       8'h8B
`define T01_ADDR_T0HI       8'h8C
`define T01_ADDR_T1HI       8'h8D

`define T01_CTRL_TF1        7
`define T01_CTRL_TR1        6
`define T01_CTRL_TF0        5
`define T01_CTRL_TR0        4
`define T01_CTRL_IE1        3
`define T01_CTRL_IT1        2
`define T01_CTRL_IE0        1
`define T01_CTRL_IT0        0

`define T01_MODE_TIMER1_PIN_GATING      7
`define T01_MODE_CT1        6
`define T01_MODE_M1_HI      5
`define T01_MODE_M1_LO      4
`define T01_MODE_TIMER0_PIN_GATING      3
`define T01_MODE_CT0        2
`define T01_MODE_M0_HI      1
`define T01_MODE_M0_LO      0

`define T01_RESET_BYTE      8'h00
`define T01_TICK_DIV        2
`define T01_PRESCALE_TOP    5'h1F

`endif

// ### inc/timer01_pkg.sv
/*
 * Types shared by the timer block: timer modes and register bus carrier.
 * Assumes timer01_map.svh holds all numeric constants.
 */
package timer01_pkg;

    typedef enum logic [1:0]
    {
        MODE_PRESCALE13 = 2'b00,
        MODE_COUNT16    = 2'b01,
        MODE_RELOAD8    = 2'b10,
        MODE_SPLIT_STOP = 2'b11
    } timer_mode_t;

    typedef struct packed
    {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed
    {
        logic tick;
        logic overflow_hi;
        logic overflow_lo;
    } cnt_evt_t;

endpackage : timer01_pkg

// ### rtl/timer_core.sv
/*
 * One 8+8 bit timer/counter core with the four classic modes.
 * Assumes enables come from the same clock domain as mclk.
 */
`timescale 1ns/1ps
`include "timer01_map.svh"

module timer_core
(
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   lo_en,
    input  wire logic                   hi_en,
    input  wire timer01_pkg::timer_mode_t mode,
    input  wire logic                   split_ok,
    input  wire logic                   wr_lo,
    input  wire logic                   wr_hi,
    input  wire logic [7:0]             wdata,
    output logic       [7:0]            lo_reg,
    output logic       [7:0]            hi_reg,
    output logic                        ovf_lo,
    output logic                        ovf_hi
);

    logic [7:0] lo_next;
    logic [7:0] hi_next;

    // split mode only when the core is timer 0; otherwise code 11 stops
    always_comb
    begin
        lo_next = lo_reg;
        hi_next = hi_reg;
        ovf_lo  = 1'b0;
        ovf_hi  = 1'b0;
        unique case (mode)
            timer01_pkg::MODE_PRESCALE13:
            begin
                if (lo_en)
                begin
                    if (lo_reg[4:0] == `T01_PRESCALE_TOP)
                    begin
                        lo_next = {lo_reg[7:5], 5'h00};
                        hi_next = hi_reg + 8'h01;
                        ovf_lo  = (hi_reg == 8'hFF);
                    end
                    else
                        lo_next = lo_reg + 8'h01;
                end
            end
            timer01_pkg::MODE_COUNT16:
            begin
                if (lo_en)
                    {hi_next, lo_next} = {hi_reg, lo_reg} + 16'h0001;
                ovf_lo = lo_en && ({hi_reg, lo_reg} == 16'hFFFF);
            end
            timer01_pkg::MODE_RELOAD8:
            begin
                if (lo_en)
                    lo_next = (lo_reg == 8'hFF) ? hi_reg : lo_reg + 8'h01;
                ovf_lo = lo_en && (lo_reg == 8'hFF);
            end
            timer01_pkg::MODE_SPLIT_STOP:
            begin
                if (split_ok)
                begin
                    if (lo_en)
                        lo_next = lo_reg + 8'h01;
                    if (hi_en)
                        hi_next = hi_reg + 8'h01;
                    ovf_lo = lo_en && (lo_reg == 8'hFF);
                    ovf_hi = hi_en && (hi_reg == 8'hFF);
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            lo_reg <= `T01_RESET_BYTE;
        else if (wr_lo)
            lo_reg <= wdata;
        else
            lo_reg <= lo_next;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            hi_reg <= `T01_RESET_BYTE;
        else if (wr_hi)
            hi_reg <= wdata;
        else
            hi_reg <= hi_next;
    end

endmodule : timer_core

// ### rtl/timer01_extint_control.sv
/*
 * Control and status for timers 0 and 1 and external interrupts 0 and 1,
 * reached through the byte-wide special-function register port.
 * Assumes pins are asynchronous to mclk; CPU vector acks are one-cycle pulses.
 */
`timescale 1ns/1ps
`include "timer01_map.svh"

module timer01_extint_control
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire timer01_pkg::sfr_req_t sfr_req,
    output logic      [7:0]            sfr_rdata,
    input  wire logic                  ext_irq0_pin,
    input  wire logic                  ext_irq1_pin,
    input  wire logic                  timer0_event_pin,
    input  wire logic                  timer1_count_pin,
    input  wire logic                  ack_timer0,
    input  wire logic                  ack_timer1,
    input  wire logic                  ack_ext0,
    input  wire logic                  ack_ext1,
    output logic                       ext0_req,
    output logic                       ext1_req,
    output logic                       timer0_req,
    output logic                       timer1_req
);

    logic [7:0] tctrl_reg;
    logic [7:0] tmode_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] prev_reg;
    logic       half_reg;
    logic [3:0] fall;
    logic       tick0;
    logic       tick1;
    logic       run0;
    logic       run1;
    logic       t0_ovf_lo;
    logic       t0_ovf_hi;
    logic       t1_ovf;
    logic       t0_split;
    logic [7:0] t0_lo;
    logic [7:0] t0_hi;
    logic [7:0] t1_lo;
    logic [7:0] t1_hi;
    timer01_pkg::timer_mode_t mode0;
    timer01_pkg::timer_mode_t mode1;

    function automatic logic wr_to(input timer01_pkg::sfr_req_t r, input logic [7:0] a);
        wr_to = r.wr && (r.addr == a);
    endfunction : wr_to

    // pins: {t1 count, t0 count, ext1, ext0}, two-stage synchronisers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= 4'hF;
            sync2_reg <= 4'hF;
            prev_reg  <= 4'hF;
        end
        else
        begin
            sync1_reg <= {timer1_count_pin, timer0_event_pin, ext_irq1_pin, ext_irq0_pin};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign fall = prev_reg & ~sync2_reg;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            half_reg <= 1'b0;
        else
            half_reg <= ~half_reg;
    end

    assign mode0 = timer01_pkg::timer_mode_t'(tmode_reg[`T01_MODE_M0_HI:`T01_MODE_M0_LO]);
    assign mode1 = timer01_pkg::timer_mode_t'(tmode_reg[`T01_MODE_M1_HI:`T01_MODE_M1_LO]);
    assign t0_split = (mode0 == timer01_pkg::MODE_SPLIT_STOP);

    // source select: half-rate tick or count pin falling edge
    assign tick0 = tmode_reg[`T01_MODE_CT0] ? fall[2] : half_reg;
    assign tick1 = tmode_reg[`T01_MODE_CT1] ? fall[3] : half_reg;
    assign run0 = tctrl_reg[`T01_CTRL_TR0]
                  && (!tmode_reg[`T01_MODE_TIMER0_PIN_GATING] || sync2_reg[0]);
    assign run1 = tctrl_reg[`T01_CTRL_TR1]
                  && (!tmode_reg[`T01_MODE_TIMER1_PIN_GATING] || sync2_reg[1]);

    timer_core u_timer0
    (
        .mclk     (mclk),
        .rst      (rst),
        .lo_en    (run0 && tick0),
        .hi_en    (tctrl_reg[`T01_CTRL_TR1] && half_reg),
        .mode     (mode0),
        .split_ok (1'b1),
        .wr_lo    (wr_to(sfr_req, `T01_ADDR_T0LO)),
        .wr_hi    (wr_to(sfr_req, `T01_ADDR_T0HI)),
        .wdata    (sfr_req.wdata),
        .lo_reg   (t0_lo),
        .hi_reg   (t0_hi),
        .ovf_lo   (t0_ovf_lo),
        .ovf_hi   (t0_ovf_hi)
    );

    // code 11 halts timer 1 core (split_ok low)
    timer_core u_timer1
    (
        .mclk     (mclk),
        .rst      (rst),
        .lo_en    (run1 && tick1),
        .hi_en    (1'b0),
        .mode     (mode1),
        .split_ok (1'b0),
        .wr_lo    (wr_to(sfr_req, `T01_ADDR_T1LO)),
        .wr_hi    (wr_to(sfr_req, `T01_ADDR_T1HI)),
        .wdata    (sfr_req.wdata),
        .lo_reg   (t1_lo),
        .hi_reg   (t1_hi),
        .ovf_lo   (t1_ovf),
        .ovf_hi   ()
    );

    // control register: set wins over clear from software or ack
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            tctrl_reg <= `T01_RESET_BYTE;
        else
        begin
            if (wr_to(sfr_req, `T01_ADDR_TCTRL))
                tctrl_reg <= sfr_req.wdata;
            if (ack_timer1)
                tctrl_reg[`T01_CTRL_TF1] <= 1'b0;
            if (ack_timer0)
                tctrl_reg[`T01_CTRL_TF0] <= 1'b0;
            if (ack_ext1 && tctrl_reg[`T01_CTRL_IT1])
                tctrl_reg[`T01_CTRL_IE1] <= 1'b0;
            if (ack_ext0 && tctrl_reg[`T01_CTRL_IT0])
                tctrl_reg[`T01_CTRL_IE0] <= 1'b0;
            if (t1_ovf || (t0_split && t0_ovf_hi))
                tctrl_reg[`T01_CTRL_TF1] <= 1'b1;
            if (t0_ovf_lo)
                tctrl_reg[`T01_CTRL_TF0] <= 1'b1;
            // edge flag latched always; level mode mirrors the low pin
            if (tctrl_reg[`T01_CTRL_IT1] ? fall[1] : !sync2_reg[1])
                tctrl_reg[`T01_CTRL_IE1] <= 1'b1;
            else if (!tctrl_reg[`T01_CTRL_IT1])
                tctrl_reg[`T01_CTRL_IE1] <= 1'b0;
            if (tctrl_reg[`T01_CTRL_IT0] ? fall[0] : !sync2_reg[0])
                tctrl_reg[`T01_CTRL_IE0] <= 1'b1;
            else if (!tctrl_reg[`T01_CTRL_IT0])
                tctrl_reg[`T01_CTRL_IE0] <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            tmode_reg <= `T01_RESET_BYTE;
        else if (wr_to(sfr_req, `T01_ADDR_TMODE))
            tmode_reg <= sfr_req.wdata;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ext0_req   <= 1'b0;
            ext1_req   <= 1'b0;
            timer0_req <= 1'b0;
            timer1_req <= 1'b0;
        end
        else
        begin
            ext0_req   <= tctrl_reg[`T01_CTRL_IE0];
            ext1_req   <= tctrl_reg[`T01_CTRL_IE1];
            timer0_req <= tctrl_reg[`T01_CTRL_TF0];
            timer1_req <= tctrl_reg[`T01_CTRL_TF1];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            sfr_rdata <= 8'h00;
        else
        begin
            unique case (sfr_req.addr)
                `T01_ADDR_TCTRL: sfr_rdata <= tctrl_reg;
                `T01_ADDR_TMODE: sfr_rdata <= tmode_reg;
                `T01_ADDR_T0LO:  sfr_rdata <= t0_lo;
                `T01_ADDR_T1LO:  sfr_rdata <= t1_lo;
                `T01_ADDR_T0HI:  sfr_rdata <= t0_hi;
                `T01_ADDR_T1HI:  sfr_rdata <= t1_hi;
                default:         sfr_rdata <= 8'h00;
            endcase
        end
    end

    sequence ext0_fall_s;
        fall[0] && tctrl_reg[`T01_CTRL_IT0];
    endsequence

    // timer 1 running as a 16-bit timer with no software load
    sequence t1_timer16_s;
        !tmode_reg[`T01_MODE_CT1] && run1 && mode1 == timer01_pkg::MODE_COUNT16
        && !wr_to(sfr_req, `T01_ADDR_T1LO) && !wr_to(sfr_req, `T01_ADDR_T1HI);
    endsequence

    edge_flag0_a: assert property (@(posedge mclk) disable iff (rst)
        ext0_fall_s |=> tctrl_reg[`T01_CTRL_IE0])
        else $error("ext0 edge flag not set");
    edge_flag1_a: assert property (@(posedge mclk) disable iff (rst)
        fall[1] && tctrl_reg[`T01_CTRL_IT1] |=> tctrl_reg[`T01_CTRL_IE1])
        else $error("ext1 edge flag not set");
    level_ext0_a: assert property (@(posedge mclk) disable iff (rst)
        !tctrl_reg[`T01_CTRL_IT0] && !sync2_reg[0] |=> tctrl_reg[`T01_CTRL_IE0])
        else $error("ext0 level not seen");
    level_ext1_a: assert property (@(posedge mclk) disable iff (rst)
        !tctrl_reg[`T01_CTRL_IT1] && sync2_reg[1] && !wr_to(sfr_req, `T01_ADDR_TCTRL)
        |=> !tctrl_reg[`T01_CTRL_IE1])
        else $error("ext1 level flag stuck");
    tf0_set_a: assert property (@(posedge mclk) disable iff (rst)
        t0_ovf_lo |=> tctrl_reg[`T01_CTRL_TF0] ##1 timer0_req)
        else $error("timer0 overflow lost");
    tf1_set_a: assert property (@(posedge mclk) disable iff (rst)
        t1_ovf |=> tctrl_reg[`T01_CTRL_TF1])
        else $error("timer1 overflow lost");
    tf1_ack_a: assert property (@(posedge mclk) disable iff (rst)
        ack_timer1 && !t1_ovf && !t0_ovf_hi && !wr_to(sfr_req, `T01_ADDR_TCTRL)
        |=> !tctrl_reg[`T01_CTRL_TF1])
        else $error("timer1 flag not cleared");
    timer0_pin_gating_hold_a: assert property (@(posedge mclk) disable iff (rst)
        tmode_reg[`T01_MODE_TIMER0_PIN_GATING] && !sync2_reg[0] && !wr_to(sfr_req, `T01_ADDR_T0LO)
        |=> t0_lo == $past(t0_lo))
        else $error("timer0 ran with gate low");
    tick_rate_a: assert property (@(posedge mclk) disable iff (rst)
        t1_timer16_s ##1 t1_timer16_s
        |=> {t1_hi, t1_lo} == {$past(t1_hi, 2), $past(t1_lo, 2)} + 16'h0001)
        else $error("timer1 tick rate wrong");
    stop_mode_a: assert property (@(posedge mclk) disable iff (rst)
        mode1 == timer01_pkg::MODE_SPLIT_STOP && !wr_to(sfr_req, `T01_ADDR_T1LO)
        |=> t1_lo == $past(t1_lo))
        else $error("timer1 moved while stopped");

endmodule : timer01_extint_control

// ### dv/pin_model.sv
/*
 * Far-side model: external interrupt pins and both timer count pins.
 * Assumes pins idle high and change only at the falling edge of mclk.
 */
`timescale 1ns/1ps

module pin_model
(
    input  wire logic       mclk,
    output logic      [3:0] pin
);
    // 0 ext_irq0, 1 ext_irq1, 2 timer0 event, 3 timer1 count
    initial pin = 4'hF;

    task automatic drive(input int i, input logic v);
        @(negedge mclk);
        pin[i] = v;
    endtask : drive

    // low then high, long enough for the input synchronisers
    task automatic fall(input int i);
        drive(i, 1'b0);
        repeat (3) @(negedge mclk);
        drive(i, 1'b1);
        repeat (3) @(negedge mclk);
    endtask : fall
endmodule : pin_model

// ### dv/tb.sv
/*
 * Self-checking bench for the timer and external interrupt control block.
 * Assumes pin_model drives the pins; acks are one-cycle pulses.
 */
`timescale 1ns/1ps

module tb;
    logic                  mclk;
    logic                  rst;
    timer01_pkg::sfr_req_t req;
    logic [7:0]            rdata;
    logic [3:0]            pin;
    logic [3:0]            ack;
    logic [3:0]            irq;
    int                    num_errors;
    int                    checked;

    pin_model pm (.mclk(mclk), .pin(pin));

    timer01_extint_control DUT
    (
        .mclk(mclk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
        .ext_irq0_pin(pin[0]), .ext_irq1_pin(pin[1]),
        .timer0_event_pin(pin[2]), .timer1_count_pin(pin[3]),
        .ack_timer0(ack[0]), .ack_timer1(ack[1]), .ack_ext0(ack[2]), .ack_ext1(ack[3]),
        .timer0_req(irq[0]), .timer1_req(irq[1]), .ext0_req(irq[2]), .ext1_req(irq[3])
    );

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task tally_and_finish;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        req = {1'b1, a, d};
        @(negedge mclk);
        req.wr = 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        req.addr = a;
        @(negedge mclk);
        d = rdata;
    endtask : rd

    task pulse(input int i);
        @(negedge mclk);
        ack[i] = 1'b1;
        @(negedge mclk);
        ack[i] = 1'b0;
    endtask : pulse

    task idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle

    // bounded poll of one register bit
    task wait_bit(input logic [7:0] a, input int b, input logic v);
        logic [7:0] d;
        int         n;
        for (n = 0; n < 100; n++)
        begin
            rd(a, d);
            if (d[b] === v)
                break;
        end
        if (n == 100)
        begin
            num_errors++;
            tally_and_finish();
        end
    endtask : wait_bit

    task t_reset;
        logic [7:0] d;
        for (int a = 8'h88; a <= 8'h8E; a++)
        begin
            rd(8'(a), d);
            check(d, 8'h00);
        end
    endtask : t_reset

    // timer 0 overflow in modes 00, 01 and 10
    task t_overflow;
        logic [7:0] d;
        for (int m = 0; m < 3; m++)
        begin
            wr(8'h89, 8'(m));
            wr(8'h8A, (m == 0) ? 8'h1E : 8'hFE);
            wr(8'h8C, (m == 2) ? 8'h00 : 8'hFF);
            wr(8'h88, 8'h10);
            wait_bit(8'h88, 5, 1'b1);
            idle(1);
            check({7'h00, irq[0]}, 8'h01);
            pulse(0);
            rd(8'h88, d);
            check(d, 8'h10);
            check({7'h00, irq[0]}, 8'h00);
            rd(8'h8A, d);
            check({7'h00, d < 8'h20}, 8'h01);
            wr(8'h88, 8'h00);
        end
    endtask : t_overflow

    task t_timer1;
        logic [7:0] d;
        logic [7:0] e;
        wr(8'h89, 8'h10);
        wr(8'h8B, 8'hFE);
        wr(8'h8D, 8'hFF);
        wr(8'h88, 8'h40);
        wait_bit(8'h88, 7, 1'b1);
        idle(1);
        check({7'h00, irq[1]}, 8'h01);
        pulse(1);
        rd(8'h88, d);
        check(d, 8'h40);
        check({7'h00, irq[1]}, 8'h00);
        wr(8'h88, 8'h00);
        wr(8'h8B, 8'h00);
        wr(8'h88, 8'h40);
        idle(40);
        wr(8'h88, 8'h00);
        rd(8'h8B, d);
        check({7'h00, d >= 8'h12 && d <= 8'h16}, 8'h01);
        idle(10);
        rd(8'h8B, e);
        check(e, d);
        wr(8'h89, 8'h30);
        wr(8'h88, 8'h40);
        idle(20);
        rd(8'h8B, e);
        check(e, d);
        wr(8'h88, 8'h00);
    endtask : t_timer1

    task t_gate;
        logic [7:0] d;
        wr(8'h89, 8'h99);
        wr(8'h8A, 8'h00);
        wr(8'h8B, 8'h00);
        pm.drive(0, 1'b0);
        pm.drive(1, 1'b0);
        wr(8'h88, 8'h50);
        idle(20);
        rd(8'h8A, d);
        check(d, 8'h00);
        rd(8'h8B, d);
        check(d, 8'h00);
        pm.drive(0, 1'b1);
        pm.drive(1, 1'b1);
        idle(20);
        rd(8'h8A, d);
        check({7'h00, d != 8'h00}, 8'h01);
        rd(8'h8B, d);
        check({7'h00, d != 8'h00}, 8'h01);
        wr(8'h88, 8'h00);
    endtask : t_gate

    task t_counter;
        logic [7:0] d;
        wr(8'h89, 8'h55);
        wr(8'h8A, 8'h00);
        wr(8'h8B, 8'h00);
        wr(8'h88, 8'h50);
        repeat (5)
        begin
            pm.fall(2);
            pm.fall(3);
        end
        idle(4);
        rd(8'h8A, d);
        check(d, 8'h05);
        rd(8'h8B, d);
        check(d, 8'h05);
        wr(8'h88, 8'h00);
    endtask : t_counter

    // edge mode latches and acks; level mode follows the pin
    task t_ext;
        logic [7:0] d;
        for (int i = 0; i < 2; i++)
        begin
            wr(8'h88, 8'h05);
            pm.fall(i);
            wait_bit(8'h88, 1 + 2 * i, 1'b1);
            idle(10);
            check({7'h00, irq[2 + i]}, 8'h01);
            pulse(2 + i);
            rd(8'h88, d);
            check(d, 8'h05);
            check({7'h00, irq[2 + i]}, 8'h00);
            wr(8'h88, 8'h00);
            pm.drive(i, 1'b0);
            wait_bit(8'h88, 1 + 2 * i, 1'b1);
            pulse(2 + i);
            rd(8'h88, d);
            check(d, 8'h02 << (2 * i));
            pm.drive(i, 1'b1);
            wait_bit(8'h88, 1 + 2 * i, 1'b0);
        end
    endtask : t_ext

    task t_split;
        logic [7:0] d;
        wr(8'h89, 8'h33);
        wr(8'h8A, 8'h00);
        wr(8'h8C, 8'hFE);
        wr(8'h88, 8'h40);
        wait_bit(8'h88, 7, 1'b1);
        rd(8'h8A, d);
        check(d, 8'h00);
        pulse(1);
        wr(8'h88, 8'h00);
    endtask : t_split

    initial
    begin
        rst = 1'b1;
        req = '0;
        ack = 4'h0;
        num_errors = 0;
        checked = 0;
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        t_reset;
        t_overflow;
        t_timer1;
        t_gate;
        t_counter;
        t_ext;
        t_split;
        tally_and_finish;
    end
endmodule : tb
